/* File: verilog/tmc_consts.svh */
/*
 Register offsets, field positions and reset values of the timer mask/compare slice.
 Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TMC_OFS_MASK 12'h000
`define TMC_OFS_SNAP 12'h004
`define TMC_OFS_CMPA 12'h008
`define TMC_OFS_CMPB 12'h00C
`define TMC_OFS_STAT 12'h010
`define TMC_OFS_SCLR 12'h014
`define TMC_OFS_CTRL 12'h018
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMC_BIT_MATCH_A 0
`define TMC_BIT_MATCH_B 1
`define TMC_BIT_OVF 2
`define TMC_BIT_CLR_EN 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMC_RST_MASK 3'h0
`define TMC_RST_CMP 16'h0000
`define TMC_RST_STAT 3'h0
`define TMC_RST_DATA 32'h0000_0000
`endif

/* File: verilog/tmc_pkg.sv */
/*
 Types and the address decoder of the timer mask/compare slice.
 Assumes tmc_consts.svh is on the include path.
*/
`include "tmc_consts.svh"
package tmc_pkg;
   // Register selected by an APB address
   typedef enum logic [2:0] {
      TMC_R_MASK = 3'h0,
      TMC_R_SNAP = 3'h1,
      TMC_R_CMPA = 3'h2,
      TMC_R_CMPB = 3'h3,
      TMC_R_STAT = 3'h4,
      TMC_R_SCLR = 3'h5,
      TMC_R_CTRL = 3'h6,
      TMC_R_NONE = 3'h7
   } tmc_reg_t;

   // Address to register; anything unmapped gives TMC_R_NONE
   function automatic tmc_reg_t tmc_decode(input logic [11:0] addr);
      case (addr)
         `TMC_OFS_MASK: tmc_decode = TMC_R_MASK;
         `TMC_OFS_SNAP: tmc_decode = TMC_R_SNAP;
         `TMC_OFS_CMPA: tmc_decode = TMC_R_CMPA;
         `TMC_OFS_CMPB: tmc_decode = TMC_R_CMPB;
         `TMC_OFS_STAT: tmc_decode = TMC_R_STAT;
         `TMC_OFS_SCLR: tmc_decode = TMC_R_SCLR;
         `TMC_OFS_CTRL: tmc_decode = TMC_R_CTRL;
         default: tmc_decode = TMC_R_NONE;
      endcase
   endfunction : tmc_decode
endpackage : tmc_pkg

/* File: verilog/tmc_top.sv */
/*
 Mask, counter snapshot and compare registers of one 16-bit timer channel,
 with the event flags and the masked interrupt, behind an APB slave.
 Assumes the up-counter runs outside on pclk and hands its value and
 its overflow pulse in on the same clock, and applies counter_clear.
*/
// The implementer's own choices: the APB register port and the placing of the registers.
// Function
// - Mask bit 2 gates the overflow interrupt; bits 31..3 read zero.
// - Mask bit 1 gates the compare-b match interrupt.
// - Mask bit 0 gates the compare-a match interrupt.
// - Snapshot read returns the live counter in bits 15..0, upper zero, read-only.
// - Compare a holds a 16-bit read/write value, reset zero, matched to counter.
// - Compare b holds a 16-bit read/write value, reset zero, matched to counter.
// - Flags set on every event regardless of mask; only enabled ones interrupt.
// - Reading the status register clears those of the overflow and match flags that the read returned set.
// - With clear enable set, a compare-b match clears the up-counter.
`include "tmc_consts.svh"
module tmc_top
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Up-counter link
   input wire logic [15:0] count_value,
   input wire logic overflow_event,
   output logic counter_clear,
   // Interrupt
   output logic irq
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [2:0] irq_mask;
   logic [15:0] compare_a;
   logic [15:0] compare_b;
   logic [2:0] status;
   logic clear_enable;
   logic eq_a_d;
   logic eq_b_d;
   tmc_reg_t acc_sel;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire setup = psel & ~penable;
   wire done = psel & penable & pready;
   wire wr_done = done & pwrite;
   wire rd_done = done & ~pwrite;
   wire tmc_reg_t sel = tmc_decode(paddr);
   wire wr_mask = wr_done & (acc_sel == TMC_R_MASK);
   wire wr_cmpa = wr_done & (acc_sel == TMC_R_CMPA);
   wire wr_cmpb = wr_done & (acc_sel == TMC_R_CMPB);
   wire wr_sclr = wr_done & (acc_sel == TMC_R_SCLR);
   wire wr_ctrl = wr_done & (acc_sel == TMC_R_CTRL);
   wire rd_stat = rd_done & (acc_sel == TMC_R_STAT);

   // ----------------------------------------
   // Events
   // ----------------------------------------
   // Matches fire on the first cycle of equality only, so a counter that
   // sits on the compare value does not raise a flag every cycle.
   wire eq_a = (count_value == compare_a);
   wire eq_b = (count_value == compare_b);
   wire match_a_ev = eq_a & ~eq_a_d;
   wire match_b_ev = eq_b & ~eq_b_d;
   wire [2:0] events = {overflow_event, match_b_ev, match_a_ev};

   // Read clears only the bits that software saw, so an event landing
   // between the data sample and the access edge is kept.
   wire [2:0] rd_clr = rd_stat ? prdata[2:0] : 3'h0;
   wire [2:0] wr_clr = wr_sclr ? pwdata[2:0] : 3'h0;
   // Set wins over any clear in the same cycle
   wire [2:0] next_status = (status & ~(rd_clr | wr_clr)) | events;
   wire [2:0] next_mask = wr_mask ? pwdata[2:0] : irq_mask;
   wire next_irq = |(next_status & next_mask);
   wire next_clear = match_b_ev & clear_enable;

   // ----------------------------------------
   // Read data select
   // ----------------------------------------
   wire [31:0] rd_mux =
      (sel == TMC_R_MASK) ? {29'h0, irq_mask} :
      (sel == TMC_R_SNAP) ? {16'h0, count_value} :
      (sel == TMC_R_CMPA) ? {16'h0, compare_a} :
      (sel == TMC_R_CMPB) ? {16'h0, compare_b} :
      (sel == TMC_R_STAT) ? {29'h0, status} :
      (sel == TMC_R_CTRL) ? {29'h0, clear_enable, 2'h0} :
      `TMC_RST_DATA;
   wire [31:0] next_rdata = (setup & ~pwrite) ? rd_mux : `TMC_RST_DATA;
   wire next_err = setup & (sel == TMC_R_NONE);

   // ----------------------------------------
   // Bus response
   // ----------------------------------------
   // One wait-free access phase: data is sampled at setup, pready follows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `TMC_RST_DATA;
         acc_sel <= TMC_R_NONE;
      end else begin
         pready <= setup;
         pslverr <= next_err;
         prdata <= next_rdata;
         acc_sel <= setup ? sel : acc_sel;
      end
   end

   // Mask and control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= `TMC_RST_MASK;
         clear_enable <= 1'b0;
      end else begin
         irq_mask <= next_mask;
         if (wr_ctrl) begin
            clear_enable <= pwdata[`TMC_BIT_CLR_EN];
         end
      end
   end

   // Compare registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_a <= `TMC_RST_CMP;
         compare_b <= `TMC_RST_CMP;
      end else begin
         if (wr_cmpa) begin
            compare_a <= pwdata[15:0];
         end
         if (wr_cmpb) begin
            compare_b <= pwdata[15:0];
         end
      end
   end

   // Flags, edge history and outputs to the channel
   // Equality history resets high so a zero counter at release is no match.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= `TMC_RST_STAT;
         eq_a_d <= 1'b1;
         eq_b_d <= 1'b1;
         irq <= 1'b0;
         counter_clear <= 1'b0;
      end else begin
         status <= next_status;
         eq_a_d <= eq_a;
         eq_b_d <= eq_b;
         irq <= next_irq;
         counter_clear <= next_clear;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup_rd(tmc_reg_t r);
      psel && !penable && !pwrite && tmc_decode(paddr) == r;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence

   sequence s_write(tmc_reg_t r);
      psel && penable && pready && pwrite && acc_sel == r;
   endsequence

   // A flag that is being cleared, or a mask bit being written off, may
   // legally drop the interrupt, so the gates only hold a surviving flag.
   a_ovf_irq_gate: assert property (
      (status[`TMC_BIT_OVF] && next_mask[`TMC_BIT_OVF]
       && !rd_clr[`TMC_BIT_OVF] && !wr_clr[`TMC_BIT_OVF]) |=> irq)
      else $error("overflow flag enabled but no interrupt");
   a_mb_irq_gate: assert property (
      (status[`TMC_BIT_MATCH_B] && next_mask[`TMC_BIT_MATCH_B]
       && !rd_clr[`TMC_BIT_MATCH_B] && !wr_clr[`TMC_BIT_MATCH_B]) |=> irq)
      else $error("match b flag enabled but no interrupt");
   a_ma_irq_gate: assert property (
      (status[`TMC_BIT_MATCH_A] && next_mask[`TMC_BIT_MATCH_A]
       && !rd_clr[`TMC_BIT_MATCH_A] && !wr_clr[`TMC_BIT_MATCH_A]) |=> irq)
      else $error("match a flag enabled but no interrupt");
   // A mask write may enable a flag that is already set, so the mask seen
   // is the one that takes effect at this edge.
   a_irq_masked_off: assert property (
      ($past((status | events) & next_mask) == 3'h0) |-> !irq)
      else $error("interrupt without enabled flag");
   a_snap_live: assert property (
      s_setup_rd(TMC_R_SNAP) |=> prdata == {16'h0, $past(count_value)} && pready)
      else $error("snapshot read not live counter");
   a_mask_upper: assert property (
      s_setup_rd(TMC_R_MASK) |=> prdata[31:3] == 29'h0)
      else $error("mask upper bits not zero");
   a_cmpa_write: assert property (
      (s_access and pwrite && paddr == `TMC_OFS_CMPA) |=> compare_a == $past(pwdata[15:0]))
      else $error("compare a write lost");
   a_cmpb_write: assert property (
      (s_access and pwrite && paddr == `TMC_OFS_CMPB) |=> compare_b == $past(pwdata[15:0]))
      else $error("compare b write lost");
   a_flag_sets: assert property (
      match_a_ev |=> status[`TMC_BIT_MATCH_A])
      else $error("match a event did not set flag");
   a_stat_rdclr: assert property (
      (s_access and !pwrite && acc_sel == TMC_R_STAT && events == 3'h0)
      |=> (status & $past(prdata[2:0])) == 3'h0)
      else $error("status read did not clear flags");
   a_clear_on_b: assert property (
      (match_b_ev && clear_enable) |=> counter_clear ##1 !counter_clear || match_b_ev)
      else $error("counter clear missing on match b");
   a_no_clear_off: assert property (
      !$past(clear_enable) |-> !counter_clear)
      else $error("counter cleared while disabled");

   // ----------------------------------------
   // Further register checks
   // ----------------------------------------
   // The mask takes exactly the three low write bits at the access edge
   a_mask_write: assert property (
      s_write(TMC_R_MASK) |=> irq_mask == $past(pwdata[2:0]))
      else $error("mask write lost");

   // Compare registers read back with zero upper halves
   a_cmpa_upper: assert property (
      s_setup_rd(TMC_R_CMPA) |=> prdata[31:16] == 16'h0)
      else $error("compare a upper bits not zero");
   a_cmpb_upper: assert property (
      s_setup_rd(TMC_R_CMPB) |=> prdata[31:16] == 16'h0)
      else $error("compare b upper bits not zero");

   // Every event sets its flag, whatever the mask says
   a_flag_b_sets: assert property (
      match_b_ev |=> status[`TMC_BIT_MATCH_B])
      else $error("match b event did not set flag");
   a_flag_ovf_sets: assert property (
      overflow_event |=> status[`TMC_BIT_OVF])
      else $error("overflow event did not set flag");

   // A flag stays set until software removes it
   a_flag_a_holds: assert property (
      (status[`TMC_BIT_MATCH_A] && !rd_clr[`TMC_BIT_MATCH_A]
       && !wr_clr[`TMC_BIT_MATCH_A]) |=> status[`TMC_BIT_MATCH_A])
      else $error("match a flag dropped without clear");

   // The clear register removes the written ones when no event competes
   a_sclr_clears: assert property (
      (s_write(TMC_R_SCLR) && events == 3'h0)
      |=> (status & $past(pwdata[2:0])) == 3'h0)
      else $error("status clear write did not clear flags");

   // Unmapped setups answer with an error and zero data
   a_err_unmapped: assert property (
      (psel && !penable && tmc_decode(paddr) == TMC_R_NONE)
      |=> pslverr && pready && prdata == 32'h0)
      else $error("unmapped access without error");

   // Wait-free slave: pready is a one-cycle pulse per setup
   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");

endmodule : tmc_top

/* File: verification/tmc_top_bench.sv */
/*
 Self-checking bench for the timer mask/compare slice: APB register access,
 snapshot of the live counter, event flags, masked interrupt and counter clear.
 Assumes tmc_consts.svh on the include path and tmc_pkg compiled before it.
*/
`include "tmc_consts.svh"
module tmc_top_bench
   import tmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] count_value = 16'h0000;
   logic overflow_event = 1'b0;
   logic counter_clear;
   logic irq;
   logic [31:0] rd_data;
   logic rd_err;
   logic [31:0] d;
   logic [15:0] v;
   int fails = 0;
   int tests_run = 0;
   int clr_cnt = 0;
   int c0;

   tmc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_value(count_value), .overflow_event(overflow_event),
      .counter_clear(counter_clear), .irq(irq));

   // 100 MHz clock; clear pulses are counted so a missed or doubled pulse shows
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (counter_clear === 1'b1) clr_cnt <= clr_cnt + 1;
   end

   // ----------------------------------------
   // Shared tasks and expectation helpers
   // ----------------------------------------
   task automatic end_sim();
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask : check

   // Request held until pready is sampled high; data taken at that same edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         fails++;
         end_sim();
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input string name);
      apb(1'b0, addr, 32'h0000_0000);
      check(name, rd_data, exp);
   endtask : rd

   // Narrow fields read back in the low bits only
   function automatic logic [31:0] keep(input logic [31:0] x, input int w);
      keep = x & ((32'h1 << w) - 32'h1);
   endfunction : keep

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(68298));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TMC_OFS_MASK, 32'h0, "mask reset");
      rd(`TMC_OFS_SNAP, 32'h0, "snapshot reset");
      rd(`TMC_OFS_CMPA, 32'h0, "compare a reset");
      rd(`TMC_OFS_CMPB, 32'h0, "compare b reset");
      // All ones first, so stuck-high upper bits cannot hide behind random data
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         apb(1'b1, `TMC_OFS_MASK, d);
         rd(`TMC_OFS_MASK, keep(d, 3), "mask");
         apb(1'b1, `TMC_OFS_CMPA, d);
         rd(`TMC_OFS_CMPA, keep(d, 16), "compare a");
         apb(1'b1, `TMC_OFS_CMPB, ~d);
         rd(`TMC_OFS_CMPB, keep(~d, 16), "compare b");
         count_value <= d[31:16];
         apb(1'b1, `TMC_OFS_SNAP, d);
         rd(`TMC_OFS_SNAP, {16'h0000, d[31:16]}, "snapshot");
      end
      apb(1'b0, 12'h01C, 32'h0000_0000);
      check("unmapped error", {31'h0, rd_err}, 32'h1);
      check("unmapped data", rd_data, 32'h0);
      apb(1'b1, `TMC_OFS_CTRL, 32'hFFFF_FFFF);
      rd(`TMC_OFS_CTRL, 32'h0000_0004, "control");
      apb(1'b1, `TMC_OFS_CTRL, 32'h0);
      // One pass per event: match a, match b, overflow
      for (int b = 0; b < 3; b++) begin
         v = $urandom;
         count_value <= ~v;
         apb(1'b1, `TMC_OFS_CMPA, {16'h0000, v});
         apb(1'b1, `TMC_OFS_CMPB, {16'h0000, v ^ 16'h8000});
         apb(1'b1, `TMC_OFS_CTRL, (b == 1) ? 32'h4 : 32'h0);
         apb(1'b1, `TMC_OFS_MASK, 32'h7 ^ (32'h1 << b));
         apb(1'b0, `TMC_OFS_STAT, 32'h0);
         c0 = clr_cnt;
         @(posedge pclk);
         if (b == 2) overflow_event <= 1'b1;
         else count_value <= (b == 0) ? v : v ^ 16'h8000;
         @(posedge pclk);
         overflow_event <= 1'b0;
         repeat (3) @(posedge pclk);
         check("irq masked", {31'h0, irq}, 32'h0);
         check("clear pulses", 32'(clr_cnt - c0), {31'h0, b == 1});
         apb(1'b1, `TMC_OFS_MASK, 32'h1 << b);
         repeat (2) @(posedge pclk);
         check("irq enabled", {31'h0, irq}, 32'h1);
         rd(`TMC_OFS_STAT, 32'h1 << b, "status");
         repeat (2) @(posedge pclk);
         check("irq after read", {31'h0, irq}, 32'h0);
         rd(`TMC_OFS_STAT, 32'h0, "status cleared");
      end
      // Clear register path: flag set with all masks off, then written away
      v = $urandom;
      count_value <= ~v;
      apb(1'b1, `TMC_OFS_CMPA, {16'h0000, v});
      apb(1'b1, `TMC_OFS_MASK, 32'h0);
      @(posedge pclk);
      count_value <= v;
      repeat (3) @(posedge pclk);
      rd(`TMC_OFS_STAT & 12'hFFF, 32'h1, "status before clear");
      count_value <= ~v;
      @(posedge pclk);
      count_value <= v;
      repeat (3) @(posedge pclk);
      apb(1'b1, `TMC_OFS_SCLR, 32'h7);
      rd(`TMC_OFS_STAT, 32'h0, "status after clear");
      end_sim();
   end
endmodule : tmc_top_bench
